// File: bms_assertions.sv
// Purpose: temporal checks on the boot mode and axis id selector
// Assumes: inputs held stable from reset release until boot done
// Notes: bound to the top module from the bench
`timescale 1ns/100ps
`default_nettype none
module bms_chk #(parameter HALL_W = 3) (
    input wire CLK, // clock
    input wire RST_B, // reset, active low
    input wire CE, // clock enable
    input wire FIELDBUS, // fieldbus variant
    input wire [HALL_W-1:0] HALL, // hall inputs
    input wire SETUP_VALID, // setup table good
    input wire SETUP_INVALIDATED, // invalidation mark
    input wire [3:0] ADDR, // register address
    input wire WR, // write strobe
    input wire BOOT_DONE, // decisions valid
    input wire MODE_CANOPEN, // canopen mode
    input wire MODE_VENDOR, // vendor mode
    input wire MODE_COE, // coe mode
    input wire AUTORUN, // program autostart
    input wire SLAVE, // slave mode
    input wire [7:0] NODE_ID, // axis id
    input wire [15:0] STATION_ALIAS, // station alias
    input wire LOAD_DEFAULTS, // default setup
    input wire INVALIDATE_SETUP, // invalidate pulse
    input wire [15:0] MOTION_ERR, // error register
    input wire LED_READY, // ready led
    input wire LED_ERROR, // error led
    input wire NV_WR, // nv write pulse
    input wire [15:0] NV_ADDR // nv address
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_mode_pick: assert property (
        BOOT_DONE |-> (FIELDBUS ? (MODE_COE && !MODE_CANOPEN && !MODE_VENDOR)
        : (MODE_CANOPEN != MODE_VENDOR && !MODE_COE))) else $error("mode pick wrong");
    a_auto_slave: assert property (
        BOOT_DONE |-> SLAVE != AUTORUN && !(AUTORUN && (FIELDBUS || !MODE_VENDOR
        || ($rose(BOOT_DONE) && $past(HALL) == 0)))) else $error("autostart wrong");
    a_id_nonzero: assert property (BOOT_DONE |-> NODE_ID != 8'h00) else $error("id zero");
    a_alias_map: assert property (
        BOOT_DONE && FIELDBUS |-> STATION_ALIAS == (NODE_ID == 8'hFF ? 16'h0000 : {8'h00, NODE_ID}))
        else $error("alias wrong");
    a_boot_hold: assert property (
        BOOT_DONE |=> BOOT_DONE && $stable(NODE_ID) && $stable(MODE_VENDOR) && $stable(AUTORUN))
        else $error("boot result moved");
    a_inval_once: assert property (
        INVALIDATE_SETUP |-> $rose(BOOT_DONE) ##1 !INVALIDATE_SETUP) else $error("bad pulse");
    a_inval_cause: assert property (
        $rose(BOOT_DONE) && $past(FIELDBUS) && $past(HALL) == 0 |-> INVALIDATE_SETUP)
        else $error("no pulse");
    a_setup_dflt: assert property (
        BOOT_DONE |-> LOAD_DEFAULTS == (FIELDBUS && SETUP_INVALIDATED)
        && MOTION_ERR[2] == LOAD_DEFAULTS) else $error("defaults wrong");
    a_nv_request: assert property (
        CE && WR && ADDR == 4'h4 |=> NV_WR && NV_ADDR == 16'h4000) else $error("nv write lost");
    a_led_blink: assert property (
        BOOT_DONE |=> (FIELDBUS && !SETUP_VALID && !SETUP_INVALIDATED ? LED_READY == LED_ERROR
        : LED_READY && !LED_ERROR)) else $error("leds wrong");
endmodule
`default_nettype wire

// File: bms_board.sv
// Purpose: board strap resistors and hall wiring seen at power-on
// Assumes: level codes 0 to 6 from the bench
// Notes: edge_pick gives the sample right at a level boundary
`timescale 1ns/100ps
`default_nettype none
module bms_board (
    input wire logic [2:0] code_low, // code of id_strap_low
    input wire logic [2:0] code_mid, // code of id_strap_mid
    input wire logic [2:0] code_high, // code of id_strap_high_mode
    input wire logic edge_pick, // boundary sample instead of mid band
    input wire logic halls_gnd, // all halls strapped to ground
    output logic [7:0] strap_low, // sample of id_strap_low
    output logic [7:0] strap_mid, // sample of id_strap_mid
    output logic [7:0] strap_high, // sample of id_strap_high_mode
    output logic [2:0] hall // hall lines
);
    function automatic logic [7:0] lvl(input logic [2:0] c, input logic e);
        case (c)
            3'h0: lvl = e ? 8'h11 : 8'h00;
            3'h1: lvl = e ? 8'h12 : 8'h27;
            3'h2: lvl = e ? 8'h3C : 8'h54;
            3'h3: lvl = e ? 8'h6C : 8'h80;
            3'h4: lvl = e ? 8'h94 : 8'hAC;
            3'h5: lvl = e ? 8'hC4 : 8'hD9;
            default: lvl = e ? 8'hEE : 8'hFF;
        endcase
    endfunction
    assign strap_low = lvl(code_low, edge_pick);
    assign strap_mid = lvl(code_mid, edge_pick);
    assign strap_high = lvl(code_high, edge_pick);
    // free halls show one rotor sector, so only some lines sit low
    assign hall = halls_gnd ? 3'h0 : 3'h4;
endmodule
`default_nettype wire

// File: bms_consts.vh
// Purpose: constants for the boot mode and axis id selector
// Assumes: 100 MHz clock, 8-bit strap level samples
// Notes: definitions only
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH

// ************************************************************
// strap level thresholds (sample at or above -> next level)
// ************************************************************
`define BMS_TH1 8'h12
`define BMS_TH2 8'h3C
`define BMS_TH3 8'h6C
`define BMS_TH4 8'h94
`define BMS_TH5 8'hC4
`define BMS_TH6 8'hEE
`define BMS_LEVEL_MAX 3'h6
`define BMS_MODE_SPLIT 3'h3

// ************************************************************
// identifier arithmetic
// ************************************************************
`define BMS_MUL_HIGH 8'h31
`define BMS_MUL_MID 8'h07
`define BMS_ID_NONE 8'hFF
`define BMS_ALIAS_NONE 16'h0000

// ************************************************************
// nonvolatile autorun word
// ************************************************************
`define BMS_NV_AUTORUN_ADDR 16'h4000
`define BMS_NV_AUTORUN_OFF 16'h0001

// ************************************************************
// register offsets
// ************************************************************
`define BMS_REG_STATUS 4'h0
`define BMS_REG_NODE_ID 4'h1
`define BMS_REG_ALIAS 4'h2
`define BMS_REG_MOTION_ERR 4'h3
`define BMS_REG_NV_CMD 4'h4
`define BMS_REG_STRAPS 4'h5

// ************************************************************
// status bits and error bits
// ************************************************************
`define BMS_ST_DONE 0
`define BMS_ST_CANOPEN 1
`define BMS_ST_VENDOR 2
`define BMS_ST_COE 3
`define BMS_ST_AUTORUN 4
`define BMS_ST_SLAVE 5
`define BMS_ST_DEFAULTS 6
`define BMS_ST_RESET_LOOP 7
`define BMS_MOTION_ERR_SETUP_BIT 2

// ************************************************************
// timing
// ************************************************************
`define BMS_CLK_MHZ 100
`define BMS_SETTLE_NS 1000
`define BMS_SETTLE_CYC ((`BMS_SETTLE_NS * `BMS_CLK_MHZ) / 1000)
`define BMS_BLINK_PERIOD_MS 200
`define BMS_BLINK_ON_MS 20

`endif

// File: bms_top.v
// Purpose: power-on mode, axis id, autorun and setup recovery selection
// Assumes: strap and hall inputs synchronous to CLK and stable at power-on
// Notes: decisions are taken once after reset and held until next reset
//
// Function
// R1: three strap inputs select communication mode and hardware node identifier.
// R2: each strap sample resolves into one of seven level codes 0 to 6.
// R3: high strap codes 0-2 give CANopen, codes 3-6 give vendor program mode.
// R4: node id is 49 times high term plus 7 times mid plus low.
// R5: a computed node id of zero becomes 255.
// R6: vendor program mode autostarts a stored program when one is present.
// R7: value 1 in nonvolatile word 0x4000 disables autostart on later boots.
// R8: all hall inputs low at power-on gives slave mode without autostart.
// R9: autostart disabled in nonvolatile memory gives slave mode regardless of halls.
// R10: fieldbus reset loop from corrupt setup blinks ready and error together.
// R11: fieldbus variant with all halls low invalidates the stored setup table.
// R12: after invalidation the next boot loads default setup settings.
// R13: after invalidation the next boot sets motion error register bit 2.
// R14: fieldbus variant operating mode is fixed to CoE.
// R15: fieldbus axis id comes from software setup only, values 1 to 255.
// R16: fieldbus axis id defaults to 255.
// R17: hardware id source selected in fieldbus setup gives axis id 255.
// R18: axis id 255 gives configured station alias 0.
// R19: axis id 1 to 254 gives station alias equal to the id.
// R20: straps and halls sampled once at power-on, results held until power cycle.
//
// Design decisions made here: the strobed register port and the register offsets.
`include "bms_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module bms_top #(
    parameter HALL_W = 3,
    parameter BLINK_PERIOD_CYC = `BMS_BLINK_PERIOD_MS * `BMS_CLK_MHZ * 1000,
    parameter BLINK_ON_CYC = `BMS_BLINK_ON_MS * `BMS_CLK_MHZ * 1000
) (
    input wire CLK, // system clock
    input wire RST_B, // asynchronous reset, active low
    input wire CE, // clock enable, freezes all state except the reset synchronizer when low
    input wire [7:0] STRAP_LOW, // level sample of id_strap_low
    input wire [7:0] STRAP_MID, // level sample of id_strap_mid
    input wire [7:0] STRAP_HIGH, // level sample of id_strap_high_mode
    input wire [HALL_W-1:0] HALL, // digital hall inputs
    input wire FIELDBUS, // high on the fieldbus variant
    input wire [15:0] NV_AUTORUN_WORD, // nonvolatile word at 0x4000
    input wire PROG_PRESENT, // stored_motion_program present in memory
    input wire SETUP_VALID, // setup table checksum good
    input wire SETUP_INVALIDATED, // setup table carries the invalidation mark
    input wire SETUP_ID_HW, // setup selects hardware id source
    input wire [7:0] SETUP_AXIS_ID, // axis id stored by software in setup
    input wire [3:0] ADDR, // register address
    input wire [15:0] WDATA, // register write data
    input wire WR, // register write strobe
    input wire RD, // register read strobe
    output reg [15:0] RDATA, // read data, valid the cycle after RD
    output reg BOOT_DONE, // boot decisions valid
    output reg MODE_CANOPEN, // CANopen mode selected
    output reg MODE_VENDOR, // vendor_program_bus_mode selected
    output reg MODE_COE, // CoE mode on fieldbus variant
    output reg AUTORUN, // start stored program at boot
    output reg SLAVE, // slave mode without autostart
    output reg [7:0] NODE_ID, // resulting axis identifier
    output reg [15:0] STATION_ALIAS, // configured station alias
    output reg LOAD_DEFAULTS, // load default setup settings
    output reg INVALIDATE_SETUP, // one-cycle pulse: invalidate stored setup
    output reg [15:0] MOTION_ERR, // motion_error_register
    output reg LED_READY, // ready indicator
    output reg LED_ERROR, // error indicator
    output reg NV_WR, // one-cycle nonvolatile write request
    output reg [15:0] NV_ADDR, // nonvolatile write address
    output reg [15:0] NV_WDATA // nonvolatile write data
);

    // ************************************************************
    // reset release
    // ************************************************************
    reg rst_meta;
    reg rst_n;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ************************************************************
    // level decode
    // ************************************************************
    function [2:0] level_of;
        input [7:0] s;
        begin
            if (s >= `BMS_TH6)
                level_of = `BMS_LEVEL_MAX; // R2
            else if (s >= `BMS_TH5)
                level_of = 3'h5;
            else if (s >= `BMS_TH4)
                level_of = 3'h4;
            else if (s >= `BMS_TH3)
                level_of = 3'h3;
            else if (s >= `BMS_TH2)
                level_of = 3'h2;
            else if (s >= `BMS_TH1)
                level_of = 3'h1;
            else
                level_of = 3'h0;
        end
    endfunction

    wire [2:0] code_low = level_of(STRAP_LOW); // R1
    wire [2:0] code_mid = level_of(STRAP_MID); // R1
    wire [2:0] code_high = level_of(STRAP_HIGH); // R1
    wire is_vendor = (code_high >= `BMS_MODE_SPLIT); // R3
    wire [2:0] high_term = is_vendor ? (code_high - `BMS_MODE_SPLIT) : code_high;
    wire [7:0] raw_id = `BMS_MUL_HIGH * {5'h00, high_term}
        + `BMS_MUL_MID * {5'h00, code_mid} + {5'h00, code_low}; // R4
    wire [7:0] hw_id = (raw_id == 8'h00) ? `BMS_ID_NONE : raw_id; // R5
    wire halls_low = ~|HALL;
    wire nv_off = (NV_AUTORUN_WORD == `BMS_NV_AUTORUN_OFF); // R7
    wire [7:0] sw_id = (SETUP_ID_HW || SETUP_AXIS_ID == 8'h00 || !SETUP_VALID) ?
        `BMS_ID_NONE : SETUP_AXIS_ID; // R15 R16 R17
    wire reset_loop = FIELDBUS && !SETUP_VALID && !SETUP_INVALIDATED;

    // ************************************************************
    // power-on sampling
    // ************************************************************
    localparam ST_SETTLE = 2'h0;
    localparam ST_SAMPLE = 2'h1;
    localparam ST_HOLD = 2'h2;

    reg [1:0] state;
    reg [7:0] settle_cnt;
    reg [2:0] straps_seen [0:2];
    reg reset_loop_seen;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SETTLE;
            settle_cnt <= 8'h00;
            BOOT_DONE <= 1'b0;
            MODE_CANOPEN <= 1'b0;
            MODE_VENDOR <= 1'b0;
            MODE_COE <= 1'b0;
            AUTORUN <= 1'b0;
            SLAVE <= 1'b1;
            NODE_ID <= `BMS_ID_NONE;
            STATION_ALIAS <= `BMS_ALIAS_NONE;
            LOAD_DEFAULTS <= 1'b0;
            INVALIDATE_SETUP <= 1'b0;
            MOTION_ERR <= 16'h0000;
            reset_loop_seen <= 1'b0;
            straps_seen[0] <= 3'h0;
            straps_seen[1] <= 3'h0;
            straps_seen[2] <= 3'h0;
        end else if (CE) begin
            INVALIDATE_SETUP <= 1'b0;
            case (state)
                ST_SETTLE: begin
                    if (settle_cnt == `BMS_SETTLE_CYC - 1)
                        state <= ST_SAMPLE;
                    else
                        settle_cnt <= settle_cnt + 8'h01;
                end
                ST_SAMPLE: begin
                    state <= ST_HOLD; // R20
                    BOOT_DONE <= 1'b1;
                    straps_seen[0] <= code_low;
                    straps_seen[1] <= code_mid;
                    straps_seen[2] <= code_high;
                    reset_loop_seen <= reset_loop;
                    if (FIELDBUS) begin
                        MODE_COE <= 1'b1; // R14
                        AUTORUN <= 1'b0;
                        SLAVE <= 1'b1;
                        NODE_ID <= sw_id; // R15
                        STATION_ALIAS <= (sw_id == `BMS_ID_NONE) ?
                            `BMS_ALIAS_NONE : {8'h00, sw_id}; // R18 R19
                        INVALIDATE_SETUP <= halls_low; // R11
                        LOAD_DEFAULTS <= SETUP_INVALIDATED; // R12
                        MOTION_ERR[`BMS_MOTION_ERR_SETUP_BIT] <= SETUP_INVALIDATED; // R13
                    end else begin
                        MODE_CANOPEN <= !is_vendor; // R3
                        MODE_VENDOR <= is_vendor; // R3
                        NODE_ID <= hw_id;
                        AUTORUN <= is_vendor && PROG_PRESENT && !halls_low && !nv_off; // R6 R8 R9
                        SLAVE <= !(is_vendor && PROG_PRESENT) || halls_low || nv_off; // R8 R9
                    end
                end
                ST_HOLD: begin
                    state <= ST_HOLD; // R20
                end
                default: begin
                    state <= ST_SETTLE;
                end
            endcase
        end
    end

    // ************************************************************
    // reset loop indication
    // ************************************************************
    reg [31:0] blink_cnt;

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt <= 32'h00000000;
            LED_READY <= 1'b0;
            LED_ERROR <= 1'b0;
        end else if (CE) begin
            if (reset_loop_seen) begin
                if (blink_cnt >= BLINK_PERIOD_CYC - 1)
                    blink_cnt <= 32'h00000000;
                else
                    blink_cnt <= blink_cnt + 32'h00000001;
                LED_READY <= (blink_cnt < BLINK_ON_CYC); // R10
                LED_ERROR <= (blink_cnt < BLINK_ON_CYC); // R10
            end else begin
                LED_READY <= BOOT_DONE;
                LED_ERROR <= 1'b0;
            end
        end
    end

    // ************************************************************
    // register port
    // ************************************************************
    wire [15:0] status = {8'h00, reset_loop_seen, LOAD_DEFAULTS, SLAVE, AUTORUN,
        MODE_COE, MODE_VENDOR, MODE_CANOPEN, BOOT_DONE};

    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            RDATA <= 16'h0000;
            NV_WR <= 1'b0;
            NV_ADDR <= 16'h0000;
            NV_WDATA <= 16'h0000;
        end else if (CE) begin
            NV_WR <= 1'b0;
            if (WR && ADDR == `BMS_REG_NV_CMD) begin
                NV_WR <= 1'b1; // R7
                NV_ADDR <= `BMS_NV_AUTORUN_ADDR;
                NV_WDATA <= WDATA;
            end
            if (RD) begin
                case (ADDR)
                    `BMS_REG_STATUS: RDATA <= status;
                    `BMS_REG_NODE_ID: RDATA <= {8'h00, NODE_ID};
                    `BMS_REG_ALIAS: RDATA <= STATION_ALIAS;
                    `BMS_REG_MOTION_ERR: RDATA <= MOTION_ERR;
                    `BMS_REG_NV_CMD: RDATA <= NV_WDATA;
                    `BMS_REG_STRAPS: RDATA <= {7'h00, straps_seen[2], straps_seen[1],
                        straps_seen[0]};
                    default: RDATA <= 16'h0000;
                endcase
            end else begin
                RDATA <= 16'h0000;
            end
        end
    end

endmodule

`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for the boot mode and axis id selector
// Assumes: blink counts shortened to 20 and 4 cycles
// Notes: every boot is a full reset and settle sequence
`include "bms_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1, edge_pick = 1'b0, hgnd = 1'b0, fb = 1'b0;
    logic prog = 1'b0, valid = 1'b1, inv = 1'b0, idhw = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [2:0] cl = 3'h0, cm = 3'h0, ch = 3'h0, hall;
    logic [7:0] axid = 8'h00, sl, sm, sh, node_id;
    logic [15:0] word = 16'h0000, wdata = 16'h0000, rdata, st_alias, motion_err, nv_addr, rv;
    logic [15:0] nv_wdata;
    logic [3:0] addr = 4'h0;
    logic done, m_can, m_ven, m_coe, autorun, slave, defs, invp, led_r, led_e, nv_wr;
    int failures = 0, total_checks = 0, inv_cnt = 0;
    bms_board board_u (.code_low(cl), .code_mid(cm), .code_high(ch), .edge_pick(edge_pick),
        .halls_gnd(hgnd), .strap_low(sl), .strap_mid(sm), .strap_high(sh), .hall(hall));
    bms_top #(.BLINK_PERIOD_CYC(20), .BLINK_ON_CYC(4)) dut_u (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .STRAP_LOW(sl), .STRAP_MID(sm), .STRAP_HIGH(sh), .HALL(hall), .FIELDBUS(fb),
        .NV_AUTORUN_WORD(word), .PROG_PRESENT(prog), .SETUP_VALID(valid),
        .SETUP_INVALIDATED(inv), .SETUP_ID_HW(idhw), .SETUP_AXIS_ID(axid), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .BOOT_DONE(done), .MODE_CANOPEN(m_can),
        .MODE_VENDOR(m_ven), .MODE_COE(m_coe), .AUTORUN(autorun), .SLAVE(slave),
        .NODE_ID(node_id), .STATION_ALIAS(st_alias), .LOAD_DEFAULTS(defs),
        .INVALIDATE_SETUP(invp), .MOTION_ERR(motion_err), .LED_READY(led_r), .LED_ERROR(led_e),
        .NV_WR(nv_wr), .NV_ADDR(nv_addr), .NV_WDATA(nv_wdata));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic boot(input logic f, input logic [2:0] h, m, l, input logic g, p,
        input logic [15:0] w, input logic v, iv, hw, input logic [7:0] a);
        @(posedge clk);
        {fb, ch, cm, cl, hgnd, prog, word} <= {f, h, m, l, g, p, w};
        {valid, inv, idhw, axid, edge_pick} <= {v, iv, hw, a, h[0] ^ l[0]};
        rst_b <= 1'b0;
        inv_cnt = 0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 200 && done !== 1'b1; i++) begin
            @(posedge clk);
            #1;
            if (invp === 1'b1) inv_cnt++;
        end
        check(done, 16'h0001);
    endtask
    function automatic logic [7:0] exp_id(input logic [2:0] h, m, l);
        int v;
        v = 49 * (h < 3 ? h : h - 3) + 7 * m + l;
        exp_id = (v == 0) ? 8'hFF : v[7:0];
    endfunction
    // ********************
    // scenarios
    // ********************
    task automatic t_ids();
        logic [2:0] l;
        for (int h = 0; h < 7; h++) begin
            for (int m = 0; m < 7; m++) begin
                l = 3'((h + m) % 7);
                boot(1'b0, 3'(h), 3'(m), l, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 8'h00);
                check(node_id, exp_id(3'(h), 3'(m), l));
                check({m_can, m_ven}, h < 3 ? 16'h0002 : 16'h0001);
                reg_rd(`BMS_REG_STRAPS, rv);
                check(rv, {7'h00, 3'(h), 3'(m), l});
            end
        end
        boot(1'b0, 3'h3, 3'h0, 3'h0, 1'b0, 1'b0, 16'h0000, 1'b1, 1'b0, 1'b0, 8'h00);
        check(node_id, 8'hFF);
    endtask
    task automatic ar(input logic [2:0] h, input logic p, g, input logic [15:0] w, input logic e);
        boot(1'b0, h, 3'h1, 3'h2, g, p, w, 1'b1, 1'b0, 1'b0, 8'h00);
        check({autorun, slave}, {e, !e});
    endtask
    task automatic t_autorun();
        ar(3'h4, 1'b1, 1'b0, 16'h0000, 1'b1);
        ar(3'h6, 1'b1, 1'b0, 16'h0002, 1'b1);
        ar(3'h3, 1'b0, 1'b0, 16'h0000, 1'b0);
        ar(3'h5, 1'b1, 1'b1, 16'h0000, 1'b0);
        ar(3'h4, 1'b1, 1'b0, 16'h0001, 1'b0);
        ar(3'h2, 1'b1, 1'b0, 16'h0000, 1'b0);
    endtask
    task automatic t_nv();
        reg_wr(`BMS_REG_NV_CMD, 16'h0001);
        check({nv_wr, nv_addr}, 17'h14000);
        check(nv_wdata, 16'h0001);
        reg_rd(`BMS_REG_NV_CMD, rv);
        check({nv_wr, rv}, 17'h00001);
        @(posedge clk);
        ce <= 1'b0;
        reg_wr(`BMS_REG_NV_CMD, 16'h0005);
        check(nv_wr, 16'h0000);
        @(posedge clk);
        ce <= 1'b1;
        reg_rd(`BMS_REG_NV_CMD, rv);
        check({nv_wdata, rv}, 32'h00010001);
        reg_wr(4'h9, 16'h1234);
        check(nv_wr, 16'h0000);
        reg_rd(4'hF, rv);
        check(rv, 16'h0000);
    endtask
    task automatic fbc(input logic [7:0] a, input logic hw, g, iv, input logic [7:0] eid);
        boot(1'b1, 3'h0, 3'h0, 3'h0, g, 1'b1, 16'h0000, 1'b1, iv, hw, a);
        check(node_id, eid);
        check(st_alias, eid == 8'hFF ? 16'h0000 : {8'h00, eid});
        check({m_coe, m_can, m_ven, autorun, slave}, 16'h0011);
        check(inv_cnt[15:0], {15'h0000, g});
        reg_rd(`BMS_REG_MOTION_ERR, rv);
        check({defs, rv[`BMS_MOTION_ERR_SETUP_BIT]}, {iv, iv});
        check(motion_err, {13'h0000, iv, 2'h0});
        reg_rd(`BMS_REG_NODE_ID, rv);
        check(rv, {8'h00, eid});
        reg_rd(`BMS_REG_ALIAS, rv);
        check(rv, eid == 8'hFF ? 16'h0000 : {8'h00, eid});
    endtask
    task automatic t_fieldbus();
        fbc(8'h01, 1'b0, 1'b0, 1'b0, 8'h01);
        fbc(8'hFE, 1'b0, 1'b1, 1'b0, 8'hFE);
        fbc(8'hFF, 1'b0, 1'b0, 1'b1, 8'hFF);
        fbc(8'h42, 1'b1, 1'b0, 1'b0, 8'hFF);
        fbc(8'h00, 1'b0, 1'b0, 1'b0, 8'hFF);
    endtask
    task automatic t_blink();
        int both;
        int apart;
        both = 0;
        apart = 0;
        boot(1'b1, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0, 8'h05);
        repeat (40) begin
            @(posedge clk);
            #1;
            if (led_r === 1'b1 && led_e === 1'b1) both++;
            if (led_r !== led_e) apart++;
        end
        check({both[7:0], apart[7:0]}, 16'h0800);
        reg_rd(`BMS_REG_STATUS, rv);
        check(rv, 16'h00A9);
    endtask
    task automatic t_hold();
        boot(1'b0, 3'h1, 3'h2, 3'h3, 1'b0, 1'b1, 16'h0000, 1'b1, 1'b0, 1'b0, 8'h00);
        ch <= 3'h5;
        hgnd <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check({node_id, m_can, led_r, led_e}, 16'h0216);
    endtask
    initial begin
        forever #5 clk = ~clk;
    end
    initial begin
        t_ids();
        t_autorun();
        t_nv();
        t_fieldbus();
        t_blink();
        t_hold();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end
endmodule
bind bms_top bms_chk #(.HALL_W(HALL_W)) chk_u (.CLK(CLK), .RST_B(RST_B), .CE(CE),
    .FIELDBUS(FIELDBUS), .HALL(HALL), .SETUP_VALID(SETUP_VALID),
    .SETUP_INVALIDATED(SETUP_INVALIDATED), .ADDR(ADDR), .WR(WR), .BOOT_DONE(BOOT_DONE),
    .MODE_CANOPEN(MODE_CANOPEN), .MODE_VENDOR(MODE_VENDOR), .MODE_COE(MODE_COE),
    .AUTORUN(AUTORUN), .SLAVE(SLAVE), .NODE_ID(NODE_ID), .STATION_ALIAS(STATION_ALIAS),
    .LOAD_DEFAULTS(LOAD_DEFAULTS), .INVALIDATE_SETUP(INVALIDATE_SETUP), .MOTION_ERR(MOTION_ERR),
    .LED_READY(LED_READY), .LED_ERROR(LED_ERROR), .NV_WR(NV_WR), .NV_ADDR(NV_ADDR));
`default_nettype wire
